// file: simd_packed_multimedia_unit_bench.sv
`timescale 1ns/1ps
`include "smu_defines.svh"

module simd_packed_multimedia_unit_bench;
  logic                 clk;
  logic                 reset_n;
  logic                 cmd_valid;
  logic                 wr_en;
  logic [31:0]          cmd_instr;
  logic [4:0]           wr_idx;
  logic [4:0]           rd_idx;
  logic [63:0]          wr_data;
  logic [63:0]          rd_data;
  smu_pkg::smu_issue_s  issue;
  smu_pkg::smu_result_s result;
  logic                 op_unknown;
  int                   n_mismatch = 0;
  int                   tests_run = 0;
  int                   cycles = 0;

  smu_top #(.DATA_W(64)) DUT (.clk(clk), .reset_n(reset_n), .issue(issue),
    .result(result), .op_unknown(op_unknown));

  smu_issue_model partner (.clk(clk), .cmd_valid(cmd_valid), .cmd_instr(cmd_instr),
    .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .rd_idx(rd_idx),
    .rd_data(rd_data), .issue(issue), .result(result));

  // ****************************************
  // helpers
  // ****************************************
  task automatic tally_and_finish();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic load(input logic [4:0] idx, input logic [63:0] val);
    @(posedge clk);
    wr_en   <= 1'b1;
    wr_idx  <= idx;
    wr_data <= val;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  function automatic logic [31:0] word(input logic [5:0] opc, input logic [4:0] fmt,
                                       input logic [5:0] fn, input logic [4:0] fd);
    return {opc, fmt, 5'h02, 5'h01, fd, fn};
  endfunction

  // one issue, answer looked at in the single cycle that it stands
  task automatic run(input logic [4:0] fmt, input logic [5:0] fn, input logic [4:0] fs,
                     input logic [4:0] fd, input logic [63:0] exp);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_instr <= {`SMU_COPROC_OPC, fmt, 5'h02, fs, fd, fn};
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    check({63'h0, result.valid}, 64'h1);
    check({63'h0, op_unknown}, 64'h0);
    check({59'h0, result.dest}, {59'h0, fd});
    check(result.data, exp);
    @(posedge clk);
    #1;
    check({63'h0, result.valid}, 64'h0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_min();
    load(5'h01, 64'h8000_7fff_ffff_0001);
    load(5'h02, 64'h7fff_8000_0000_fffe);
    run(`SMU_FMT_MINSH, `SMU_FN_MIN, 5'h01, 5'h03, 64'h8000_8000_ffff_fffe);
    load(5'h01, 64'h00ff_8001_7f80_fe01);
    load(5'h02, 64'hff00_0180_807f_01fe);
    run(`SMU_FMT_MINUB, `SMU_FN_MIN, 5'h01, 5'h03, 64'h0000_0101_7f7f_0101);
  endtask

  task automatic t_mask();
    load(5'h01, 64'h807f_ff00_0180_fe7f);
    load(5'h02, 64'hffff_ffff_ffff_ffff);
    run(`SMU_FMT_MASK, `SMU_FN_GATHER, 5'h01, 5'h03, 64'h0000_0000_0000_00a6);
  endtask

  task automatic t_mul();
    load(5'h01, 64'hffff_8000_7fff_0002);
    load(5'h02, 64'hffff_8000_7fff_fffd);
    run(`SMU_FMT_MULHU, `SMU_FN_MUL, 5'h01, 5'h03, 64'hfffe_4000_3fff_0001);
    run(5'h1b, 6'h0a, 5'h01, 5'h04, 64'h0000_4000_3fff_ffff);
    run(`SMU_FMT_MULLS, `SMU_FN_MUL, 5'h01, 5'h05, 64'h0001_0000_0001_fffa);
    load(5'h01, 64'h1234_5678_ffff_ffff);
    load(5'h02, 64'hdead_beef_ffff_ffff);
    run(5'h1c, 6'h0a, 5'h01, 5'h06, 64'hffff_fffe_0000_0001);
  endtask

  // two chained issues through the register file, then the largest sum
  task automatic t_sad();
    load(5'h01, 64'h00ff_1080_7f01_0a05);
    load(5'h02, 64'hff00_8010_017f_050a);
    run(`SMU_FMT_ABSD, `SMU_FN_ABSD, 5'h01, 5'h03, 64'hffff_7070_7e7e_0505);
    run(`SMU_FMT_BSUM, `SMU_FN_GATHER, 5'h03, 5'h04, 64'h0000_0000_0000_03e4);
    @(posedge clk);
    rd_idx <= 5'h04;
    #1;
    check(rd_data, 64'h0000_0000_0000_03e4);
    load(5'h01, 64'hffff_ffff_ffff_ffff);
    run(`SMU_FMT_BSUM, `SMU_FN_GATHER, 5'h01, 5'h04, 64'h0000_0000_0000_07f8);
  endtask

  // unknown words back to back with a good one: pulse, no result, data held
  task automatic t_unknown();
    load(5'h01, 64'h807f_ff00_0180_fe7f);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_instr <= word(6'h12, 5'h18, 6'h02, 5'h07);
    @(posedge clk);
    cmd_instr <= word(6'h11, 5'h1b, 6'h0a, 5'h08);
    #1;
    check({62'h0, op_unknown, result.valid}, 64'h2);
    check(result.data, 64'h0000_0000_0000_07f8);
    @(posedge clk);
    cmd_instr <= word(6'h12, 5'h1d, 6'h0f, 5'h09);
    #1;
    check({62'h0, op_unknown, result.valid}, 64'h2);
    check({59'h0, result.dest}, 64'h8);
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    check({62'h0, op_unknown, result.valid}, 64'h1);
    check(result.data, 64'h0000_0000_0000_00a6);
  endtask

  // ****************************************
  // clock, reset, sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // limit sized well above the eighty-odd cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    reset_n   = 1'b0;
    cmd_valid = 1'b0;
    cmd_instr = 32'h0;
    wr_en     = 1'b0;
    wr_idx    = 5'h00;
    wr_data   = 64'h0;
    rd_idx    = 5'h00;
    repeat (20) @(posedge clk);
    #1;
    check(result.data, 64'h0);
    check({58'h0, result.valid, result.dest}, 64'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_min();
    t_mask();
    t_mul();
    t_sad();
    t_unknown();
    tally_and_finish();
  end
endmodule // simd_packed_multimedia_unit_bench

// file: smu_defines.svh
`ifndef SMU_DEFINES_SVH
`define SMU_DEFINES_SVH

// ****************************************
// instruction word fields
// ****************************************
`define SMU_OPC_HI      31
`define SMU_OPC_LO      26
`define SMU_FMT_HI      25
`define SMU_FMT_LO      21
`define SMU_SRC_B_HI    20
`define SMU_SRC_B_LO    16
`define SMU_SRC_A_HI    15
`define SMU_SRC_A_LO    11
`define SMU_DEST_HI     10
`define SMU_DEST_LO     6
`define SMU_FUNC_HI     5
`define SMU_FUNC_LO     0

// ****************************************
// encodings
// ****************************************
`define SMU_COPROC_OPC  6'h12
`define SMU_FMT_MINSH   5'h1b
`define SMU_FMT_MINUB   5'h1d
`define SMU_FMT_MASK    5'h1d
`define SMU_FMT_MULHU   5'h1d
`define SMU_FMT_MULHS   5'h1b
`define SMU_FMT_MULLS   5'h1a
`define SMU_FMT_MULUW   5'h1c
`define SMU_FMT_ABSD    5'h19
`define SMU_FMT_BSUM    5'h1c
`define SMU_FN_MIN      6'h08
`define SMU_FN_MUL      6'h0a
`define SMU_FN_ABSD     6'h0d
`define SMU_FN_GATHER   6'h0f

// ****************************************
// reset values
// ****************************************
`define SMU_DATA_RST    64'h0
`define SMU_DEST_RST    5'h00

`endif

// file: smu_issue_model.sv
`timescale 1ns/1ps

// ****************************************
// issue logic and register file model
// ****************************************
module smu_issue_model (
  input  wire logic                 clk,
  input  wire logic                 cmd_valid,
  input  wire logic [31:0]          cmd_instr,
  input  wire logic                 wr_en,
  input  wire logic [4:0]           wr_idx,
  input  wire logic [63:0]          wr_data,
  input  wire logic [4:0]           rd_idx,
  output logic      [63:0]          rd_data,
  output smu_pkg::smu_issue_s       issue,
  input  wire smu_pkg::smu_result_s result
);
  logic [63:0] regs [32];

  initial begin
    for (int i = 0; i < 32; i++) begin
      regs[i] = 64'h0;
    end
  end

  // results land back in the file, so two issues can chain
  always @(posedge clk) begin
    if (wr_en) begin
      regs[wr_idx] <= wr_data;
    end else if (result.valid) begin
      regs[result.dest] <= result.data;
    end
  end

  // idle cycles show inverted lines, so stale operands never look valid
  always_comb begin
    issue.valid = cmd_valid;
    issue.instr = cmd_valid ? cmd_instr : ~cmd_instr;
    issue.src_a = cmd_valid ? regs[cmd_instr[15:11]] : ~regs[cmd_instr[15:11]];
    issue.src_b = cmd_valid ? regs[cmd_instr[20:16]] : ~regs[cmd_instr[20:16]];
  end

  assign rd_data = regs[rd_idx];
endmodule // smu_issue_model

// file: smu_lane.sv
`timescale 1ns/1ps

module smu_lane (
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  output logic      [15:0] min_sh,
  output logic      [15:0] min_ub,
  output logic      [15:0] absd,
  output logic      [15:0] mulhu,
  output logic      [15:0] mulhs,
  output logic      [15:0] mulls
);

  logic        [31:0] prod_u;
  logic signed [31:0] prod_s;
  logic        [15:0] absd_w;

  // ****************************************
  // compare and difference
  // ****************************************
  always_comb begin
    min_sh = ($signed(a) < $signed(b)) ? a : b;                         // [RQ1]
    min_ub[7:0]  = (a[7:0] < b[7:0]) ? a[7:0] : b[7:0];                 // [RQ2]
    min_ub[15:8] = (a[15:8] < b[15:8]) ? a[15:8] : b[15:8];             // [RQ2]
    absd_w[7:0]  = (a[7:0] >= b[7:0]) ? (a[7:0] - b[7:0]) : (b[7:0] - a[7:0]); // [RQ8]
    absd_w[15:8] = (a[15:8] >= b[15:8]) ? (a[15:8] - b[15:8])
                                        : (b[15:8] - a[15:8]);          // [RQ8]
    absd = absd_w;
  end

  // ****************************************
  // multiplies
  // ****************************************
  // full 32-bit products never overflow, so no flag is needed
  always_comb begin
    prod_u = {16'h0000, a} * {16'h0000, b};
    prod_s = $signed({{16{a[15]}}, a}) * $signed({{16{b[15]}}, b});
    mulhu  = prod_u[31:16];                                             // [RQ4]
    mulhs  = prod_s[31:16];                                             // [RQ5]
    mulls  = prod_s[15:0];                                              // [RQ6] [RQ14]
  end

endmodule // smu_lane

// file: smu_pkg.sv
package smu_pkg;

  // ****************************************
  // operation codes
  // ****************************************
  typedef enum logic [3:0] {
    SMU_OP_NONE   = 4'h0,
    SMU_OP_MIN_SH = 4'h1,
    SMU_OP_MIN_UB = 4'h2,
    SMU_OP_MASK   = 4'h3,
    SMU_OP_MULHU  = 4'h4,
    SMU_OP_MULHS  = 4'h5,
    SMU_OP_MULLS  = 4'h6,
    SMU_OP_MULUW  = 4'h7,
    SMU_OP_ABSD   = 4'h8,
    SMU_OP_BSUM   = 4'h9
  } smu_op_e;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [63:0] src_a;
    logic [63:0] src_b;
  } smu_issue_s;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [63:0] data;
  } smu_result_s;

endpackage

// file: smu_top.sv
`timescale 1ns/1ps
`include "smu_defines.svh"

// How it works
// RQ1: signed halfword lane minimum into each lane
// RQ2: unsigned byte lane minimum into each byte
// RQ3: byte top bits gathered, upper bits cleared
// RQ4: unsigned halfword product, keep high sixteen
// RQ5: signed halfword product, keep high sixteen
// RQ6: signed halfword product, keep low sixteen
// RQ7: low words multiplied unsigned, 64-bit result
// RQ8: per-byte unsigned absolute difference
// RQ9: sum of eight bytes, low halfword, rest zero
// RQ10: sad done as two separate operations
// RQ11: signed high multiply encoding recognised
// RQ12: unsigned word multiply encoding recognised
// RQ13: fixed instruction field positions decoded
// RQ14: no exceptions; overflow wraps or truncates

module smu_top #(
  parameter int DATA_W = 64
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire smu_pkg::smu_issue_s issue,
  output smu_pkg::smu_result_s     result,
  output logic                     op_unknown
);

  // ****************************************
  // parameter check
  // ****************************************
  // lane slicing below is fixed to four halfwords
  if (DATA_W != 64) begin : g_bad_width
    $error("smu_top: DATA_W must be 64");
  end

  // ****************************************
  // reset release
  // ****************************************
  logic rst_sync1_reg;
  logic rst_n_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync1_reg <= 1'b0;
      rst_n_reg     <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n_reg     <= rst_sync1_reg;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  logic [5:0]       opc;
  logic [4:0]       fmt;
  logic [5:0]       func;
  logic [4:0]       dest;
  smu_pkg::smu_op_e op;

  always_comb begin
    opc  = issue.instr[`SMU_OPC_HI:`SMU_OPC_LO];                        // [RQ13]
    fmt  = issue.instr[`SMU_FMT_HI:`SMU_FMT_LO];                        // [RQ13]
    func = issue.instr[`SMU_FUNC_HI:`SMU_FUNC_LO];                      // [RQ13]
    dest = issue.instr[`SMU_DEST_HI:`SMU_DEST_LO];                      // [RQ13]
    op   = smu_pkg::SMU_OP_NONE;
    if (opc == `SMU_COPROC_OPC) begin
      case ({fmt, func})
        {`SMU_FMT_MINSH, `SMU_FN_MIN}: begin
          op = smu_pkg::SMU_OP_MIN_SH;
        end
        {`SMU_FMT_MINUB, `SMU_FN_MIN}: begin
          op = smu_pkg::SMU_OP_MIN_UB;
        end
        {`SMU_FMT_MASK, `SMU_FN_GATHER}: begin
          op = smu_pkg::SMU_OP_MASK;
        end
        {`SMU_FMT_MULHU, `SMU_FN_MUL}: begin
          op = smu_pkg::SMU_OP_MULHU;
        end
        {`SMU_FMT_MULHS, `SMU_FN_MUL}: begin
          op = smu_pkg::SMU_OP_MULHS;                                   // [RQ11]
        end
        {`SMU_FMT_MULLS, `SMU_FN_MUL}: begin
          op = smu_pkg::SMU_OP_MULLS;
        end
        {`SMU_FMT_MULUW, `SMU_FN_MUL}: begin
          op = smu_pkg::SMU_OP_MULUW;                                   // [RQ12]
        end
        {`SMU_FMT_ABSD, `SMU_FN_ABSD}: begin
          op = smu_pkg::SMU_OP_ABSD;                                    // [RQ10]
        end
        {`SMU_FMT_BSUM, `SMU_FN_GATHER}: begin
          op = smu_pkg::SMU_OP_BSUM;                                    // [RQ10]
        end
        default: begin
          op = smu_pkg::SMU_OP_NONE;
        end
      endcase
    end
  end

  // ****************************************
  // lanes
  // ****************************************
  logic [63:0] min_sh_w;
  logic [63:0] min_ub_w;
  logic [63:0] absd_w;
  logic [63:0] mulhu_w;
  logic [63:0] mulhs_w;
  logic [63:0] mulls_w;

  for (genvar g = 0; g < 4; g++) begin : g_lane
    smu_lane u_lane (
      .a      (issue.src_a[16*g +: 16]),
      .b      (issue.src_b[16*g +: 16]),
      .min_sh (min_sh_w[16*g +: 16]),
      .min_ub (min_ub_w[16*g +: 16]),
      .absd   (absd_w[16*g +: 16]),
      .mulhu  (mulhu_w[16*g +: 16]),
      .mulhs  (mulhs_w[16*g +: 16]),
      .mulls  (mulls_w[16*g +: 16])
    );
  end

  // ****************************************
  // whole-register operations
  // ****************************************
  logic [63:0] mask_w;
  logic [63:0] bsum_w;
  logic [63:0] muluw_w;
  logic [15:0] acc;

  always_comb begin
    mask_w = 64'h0;                                                     // [RQ3]
    acc    = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      mask_w[k] = issue.src_a[8*k + 7];                                 // [RQ3]
      acc       = acc + {8'h00, issue.src_a[8*k +: 8]};                 // [RQ9]
    end
    bsum_w  = {48'h0, acc};                                             // [RQ9]
    // carry past bit 63 cannot occur for a 32x32 product
    muluw_w = {32'h0, issue.src_a[31:0]} * {32'h0, issue.src_b[31:0]}; // [RQ7] [RQ14]
  end

  // ****************************************
  // result stage
  // ****************************************
  logic [63:0] data_next;
  logic [63:0] data_reg;
  logic [4:0]  dest_next;
  logic [4:0]  dest_reg;
  logic        valid_next;
  logic        valid_reg;
  logic        unknown_next;
  logic        unknown_reg;

  always_comb begin
    data_next    = data_reg;
    dest_next    = dest_reg;
    valid_next   = 1'b0;
    unknown_next = 1'b0;
    if (issue.valid) begin
      // an unrecognised word is flagged but traps nothing
      unknown_next = (op == smu_pkg::SMU_OP_NONE);                      // [RQ14]
      valid_next   = (op != smu_pkg::SMU_OP_NONE);
      dest_next    = dest;
      case (op)
        smu_pkg::SMU_OP_MIN_SH: begin
          data_next = min_sh_w;                                         // [RQ1]
        end
        smu_pkg::SMU_OP_MIN_UB: begin
          data_next = min_ub_w;                                         // [RQ2]
        end
        smu_pkg::SMU_OP_MASK: begin
          data_next = mask_w;                                           // [RQ3]
        end
        smu_pkg::SMU_OP_MULHU: begin
          data_next = mulhu_w;                                          // [RQ4]
        end
        smu_pkg::SMU_OP_MULHS: begin
          data_next = mulhs_w;                                          // [RQ5]
        end
        smu_pkg::SMU_OP_MULLS: begin
          data_next = mulls_w;                                          // [RQ6]
        end
        smu_pkg::SMU_OP_MULUW: begin
          data_next = muluw_w;                                          // [RQ7]
        end
        smu_pkg::SMU_OP_ABSD: begin
          data_next = absd_w;                                           // [RQ8]
        end
        smu_pkg::SMU_OP_BSUM: begin
          data_next = bsum_w;                                           // [RQ9]
        end
        default: begin
          data_next = data_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      data_reg    <= `SMU_DATA_RST;
      dest_reg    <= `SMU_DEST_RST;
      valid_reg   <= 1'b0;
      unknown_reg <= 1'b0;
    end else begin
      data_reg    <= data_next;
      dest_reg    <= dest_next;
      valid_reg   <= valid_next;
      unknown_reg <= unknown_next;
    end
  end

  assign result = '{valid: valid_reg, dest: dest_reg, data: data_reg};
  assign op_unknown   = unknown_reg;

  // ****************************************
  // checks
  // ****************************************
  sequence s_issued(smu_pkg::smu_op_e o);
    issue.valid && (op == o);
  endsequence

  sequence s_answered;
    ##1 result.valid;
  endsequence

  a_min_half_lanes: assert property ( // [RQ1]
    @(posedge clk) disable iff (!rst_n_reg)
    s_issued(smu_pkg::SMU_OP_MIN_SH) |-> s_answered ##0
    ($signed(result.data[63:48]) <= $signed($past(issue.src_b[63:48])) &&
     $signed(result.data[15:0]) <= $signed($past(issue.src_a[15:0])) &&
     (result.data[15:0] == $past(issue.src_a[15:0]) ||
      result.data[15:0] == $past(issue.src_b[15:0]))))
    else $error("signed halfword minimum wrong");

  a_min_byte_lanes: assert property ( // [RQ2]
    @(posedge clk) disable iff (!rst_n_reg)
    s_issued(smu_pkg::SMU_OP_MIN_UB) |=>
    (result.data[7:0] <= $past(issue.src_a[7:0])) &&
    (result.data[63:56] <= $past(issue.src_b[63:56])))
    else $error("unsigned byte minimum wrong");

  a_mask_gather_bits: assert property ( // [RQ3]
    @(posedge clk) disable iff (!rst_n_reg)
    s_issued(smu_pkg::SMU_OP_MASK) |=>
    result.data == {56'h0, $past(issue.src_a[63]), $past(issue.src_a[55]),
                    $past(issue.src_a[47]), $past(issue.src_a[39]),
                    $past(issue.src_a[31]), $past(issue.src_a[23]),
                    $past(issue.src_a[15]), $past(issue.src_a[7])})
    else $error("byte sign mask wrong");

  a_mul_high_unsigned: assert property ( // [RQ4]
    @(posedge clk) disable iff (!rst_n_reg)
    s_issued(smu_pkg::SMU_OP_MULHU) |=>
    {16'h0, result.data[31:16]} ==
    32'(({16'h0, $past(issue.src_a[31:16])} * {16'h0, $past(issue.src_b[31:16])}) >> 16))
    else $error("unsigned high multiply wrong");

  a_mul_high_signed: assert property ( // [RQ5] [RQ11]
    @(posedge clk) disable iff (!rst_n_reg)
    s_issued(smu_pkg::SMU_OP_MULHS) |=>
    result.valid && result.data[63:48] ==
    16'((32'($signed($past(issue.src_a[63:48]))) *
         32'($signed($past(issue.src_b[63:48])))) >> 16))
    else $error("signed high multiply wrong");

  a_mul_low_signed: assert property ( // [RQ6]
    @(posedge clk) disable iff (!rst_n_reg)
    s_issued(smu_pkg::SMU_OP_MULLS) |=>
    result.data[15:0] == 16'($past(issue.src_a[15:0]) * $past(issue.src_b[15:0])))
    else $error("signed low multiply wrong");

  a_mul_word_full: assert property ( // [RQ7] [RQ12]
    @(posedge clk) disable iff (!rst_n_reg)
    s_issued(smu_pkg::SMU_OP_MULUW) |=>
    result.valid &&
    result.data == {32'h0, $past(issue.src_a[31:0])} * {32'h0, $past(issue.src_b[31:0])})
    else $error("unsigned word multiply wrong");

  a_abs_diff_byte: assert property ( // [RQ8]
    @(posedge clk) disable iff (!rst_n_reg)
    s_issued(smu_pkg::SMU_OP_ABSD) |=>
    (result.data[7:0] == $past(issue.src_a[7:0]) - $past(issue.src_b[7:0]) ||
     result.data[7:0] == $past(issue.src_b[7:0]) - $past(issue.src_a[7:0])))
    else $error("absolute difference wrong");

  a_byte_sum_clear: assert property ( // [RQ9]
    @(posedge clk) disable iff (!rst_n_reg)
    s_issued(smu_pkg::SMU_OP_BSUM) |=>
    result.valid && result.data[63:11] == 53'h0)
    else $error("byte sum upper bits not clear");

  a_dest_field_used: assert property ( // [RQ13]
    @(posedge clk) disable iff (!rst_n_reg)
    issue.valid && (op != smu_pkg::SMU_OP_NONE) |=>
    result.dest == $past(issue.instr[10:6]) && !op_unknown)
    else $error("destination field not carried");

  a_unknown_no_result: assert property ( // [RQ14]
    @(posedge clk) disable iff (!rst_n_reg)
    s_issued(smu_pkg::SMU_OP_NONE) |=> op_unknown && !result.valid)
    else $error("unknown word produced a result");

endmodule // smu_top
